//--- logic/refresh_map.svh
`ifndef REFRESH_MAP_SVH
`define REFRESH_MAP_SVH
`define ROW_W 15
`define RFC_NS 260
`define RFC_CYC ((`RFC_NS * 20 + 999) / 1000)
`define REFI_NS 7800
`define REFI_CYC ((`REFI_NS * 20) / 1000)
`define XS_CYC (`RFC_CYC + 5)
`define XSDLL_CYC 512
`define CKE_CYC 3
`define CKESR_CYC (`CKE_CYC + 1)
`define INT_REF_CYC `CKE_CYC
`define SR_TIMER_CYC 156
`define DEBT_MAX 8
`define DEBT_W 5
`define WRLVL_CYC 512
`define ODT_LEAD_CYC 6
`endif

//--- logic/refresh_pkg.sv
package refresh_pkg;
  typedef enum logic [1:0] {CMD_NOP, CMD_REF, CMD_SRE, CMD_OTHER} cmd_t;
  typedef enum logic [1:0] {DEV_IDLE, DEV_REFRESH, DEV_SELF} dev_state_t;
endpackage

//--- logic/refresh_if.sv
`timescale 1ns/100ps
`default_nettype none
interface refresh_if;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic cke;
  logic termination_control_pin;
  logic [14:0] addr;
  modport device (input cs_n, ras_n, cas_n, we_n, cke, termination_control_pin, addr);
  modport host (output cs_n, ras_n, cas_n, we_n, cke, termination_control_pin, addr);
endinterface
`default_nettype wire

//--- logic/refresh_device.sv
// Behaviour
// R01: CS RAS CAS low, WE high: refresh.
// R02: Controller refreshes only with banks idle.
// R03: Refresh row comes from internal counter.
// R04: Banks precharged idle after refresh.
// R05: Only NOP during refresh cycle time.
// R06: Controller refreshes once per average interval.
// R07: At most eight refreshes deferred.
// R08: Up to eight early refreshes credited.
// R09: Early refreshes beyond eight give nothing.
// R10: At most sixteen refreshes per two intervals.
// R11: Deferred total across self-refresh stays eight.
// R12: Refresh tally frozen during self-refresh.
// R13: Refresh command with CKE low: self-refresh entry.
// R14: Entry only from idle with CKE high.
// R15: Termination off before self-refresh entry.
// R16: Only CKE and reset matter in self-refresh.
// R17: DLL off on entry, reset on exit.
// R18: Internal refresh within tCKE, then timer.
// R19: Residency, clock stop and restart times.
// R20: Exit with CKE high, wait exit delays.
// R21: Only NOP during exit; CKE, termination hold.
// R22: Extra refresh before self-refresh re-entry.
// R23: No write leveling for 512 cycles.
// R24: Controller tracks signed refresh debt.
`timescale 1ns/100ps
`default_nettype none
`include "refresh_map.svh"
module refresh_device (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  // Command bus
  refresh_if.device bus,
  // Mode
  input wire logic dll_enable_i,
  // Status
  output logic refresh_busy_o,
  output logic self_refresh_o,
  output logic dll_on_o,
  output logic dll_reset_o,
  output logic refresh_pulse_o,
  output logic [`ROW_W-1:0] refresh_row_o,
  output logic banks_idle_o
);
  refresh_pkg::dev_state_t state;
  logic [9:0] cnt;
  logic [7:0] sr_timer;
  logic cke_prev;
  logic do_ref;
  logic do_sre;
  logic start_ref;
  logic start_sr;
  logic ref_done;
  logic do_exit;
  logic sr_tick;

  // ----------------------------------------
  // Command decode.
  // ----------------------------------------
  // Refresh and self-refresh entry share one strobe code.
  function automatic logic is_ref_code(input logic cs_n, input logic ras_n,
                                       input logic cas_n, input logic we_n);
    return !cs_n && !ras_n && !cas_n && we_n;
  endfunction

  assign do_ref = is_ref_code(bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n)
                  && cke_prev && bus.cke; // R01
  assign do_sre = is_ref_code(bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n)
                  && cke_prev && !bus.cke; // R13
  // The address bus is never read, so it cannot steer a refresh.
  assign start_ref = (state == refresh_pkg::DEV_IDLE) && do_ref;
  assign start_sr = (state == refresh_pkg::DEV_IDLE) && do_sre;
  assign ref_done = (state == refresh_pkg::DEV_REFRESH) && (cnt == 10'h000);
  assign do_exit = (state == refresh_pkg::DEV_SELF) && bus.cke; // R16
  assign sr_tick = (state == refresh_pkg::DEV_SELF) && !bus.cke && (sr_timer == 8'h00); // R18

  // ----------------------------------------
  // Clock-enable history.
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cke_prev <= 1'b1;
    end else if (clk_en_i) begin
      cke_prev <= bus.cke;
    end
  end

  // ----------------------------------------
  // State sequencing.
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state <= refresh_pkg::DEV_IDLE;
    end else if (clk_en_i) begin
      case (state)
        refresh_pkg::DEV_IDLE: begin
          if (start_ref) begin
            state <= refresh_pkg::DEV_REFRESH;
          end else if (start_sr) begin
            state <= refresh_pkg::DEV_SELF; // R13
          end
        end
        refresh_pkg::DEV_REFRESH: begin
          if (ref_done) begin
            state <= refresh_pkg::DEV_IDLE; // R04
          end
        end
        refresh_pkg::DEV_SELF: begin
          if (do_exit) begin
            state <= refresh_pkg::DEV_IDLE; // R16
          end
        end
        default: begin
          state <= refresh_pkg::DEV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Refresh cycle counter.
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      cnt <= 10'h000;
    end else if (clk_en_i) begin
      if (start_ref) begin
        cnt <= 10'(`RFC_CYC - 1);
      end else if (state == refresh_pkg::DEV_REFRESH && cnt != 10'h000) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Self-refresh timer.
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      sr_timer <= 8'h00;
    end else if (clk_en_i) begin
      if (start_sr) begin
        sr_timer <= 8'(`INT_REF_CYC - 1); // R18
      end else if (sr_tick) begin
        sr_timer <= 8'(`SR_TIMER_CYC - 1); // R18
      end else if (state == refresh_pkg::DEV_SELF && sr_timer != 8'h00) begin
        sr_timer <= sr_timer - 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Refresh pulse and row counter.
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      refresh_pulse_o <= 1'b0;
      refresh_row_o <= '0;
    end else if (clk_en_i) begin
      refresh_pulse_o <= start_ref || sr_tick; // R18
      if (start_ref || sr_tick) begin
        refresh_row_o <= refresh_row_o + 1'b1; // R03
      end
    end
  end

  // ----------------------------------------
  // Refresh busy flag.
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      refresh_busy_o <= 1'b0;
    end else if (clk_en_i) begin
      refresh_busy_o <= start_ref || (state == refresh_pkg::DEV_REFRESH && !ref_done);
    end
  end

  // ----------------------------------------
  // Bank status.
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      banks_idle_o <= 1'b1;
    end else if (clk_en_i) begin
      banks_idle_o <= 1'b1; // R04
    end
  end

  // ----------------------------------------
  // Self-refresh flag.
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      self_refresh_o <= 1'b0;
    end else if (clk_en_i) begin
      if (start_sr) begin
        self_refresh_o <= 1'b1; // R13
      end else if (do_exit) begin
        self_refresh_o <= 1'b0; // R16
      end
    end
  end

  // ----------------------------------------
  // DLL control.
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      dll_on_o <= 1'b0;
      dll_reset_o <= 1'b0;
    end else if (clk_en_i) begin
      dll_reset_o <= do_exit && dll_enable_i; // R17
      if (start_sr) begin
        dll_on_o <= 1'b0; // R17
      end else if (state != refresh_pkg::DEV_SELF || do_exit) begin
        dll_on_o <= dll_enable_i; // R17
      end
    end
  end
endmodule
`default_nettype wire

//--- logic/refresh_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "refresh_map.svh"
module refresh_host (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic clk_en_i,
  // User requests
  input wire logic sr_req_i,
  input wire logic sr_exit_i,
  // Command bus
  refresh_if.host bus,
  // Status
  output logic in_self_refresh_o,
  output logic dll_ready_o,
  output logic write_ok_o,
  output logic signed [`DEBT_W-1:0] debt_o
);
  typedef enum logic [2:0] {H_IDLE, H_REF_WAIT, H_ODT_OFF, H_SELF, H_XS, H_XSDLL} host_state_t;
  host_state_t state;
  logic [12:0] refi_cnt;
  logic [9:0] wait_cnt;
  logic [9:0] wr_cnt;
  logic ref_since_exit;
  logic issue_ref;
  logic in_sr;

  // ----------------------------------------
  // Refresh debt, frozen in self-refresh.
  // ----------------------------------------
  assign in_sr = (state == H_SELF);
  assign issue_ref = (state == H_IDLE) && (debt_o > 0 || (!sr_req_i && debt_o > -`DEBT_MAX));

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      refi_cnt <= 13'h0000;
      debt_o <= '0;
    end else if (clk_en_i && !in_sr) begin // R12 R24
      if (refi_cnt == 13'(`REFI_CYC - 1)) begin
        refi_cnt <= 13'h0000;
        debt_o <= debt_o + (issue_ref ? 5'sh00 : 5'sh01); // R06
      end else begin
        refi_cnt <= refi_cnt + 1'b1;
        if (issue_ref) begin
          debt_o <= debt_o - 5'sh01; // R08 R09
        end
      end
    end
  end

  // ----------------------------------------
  // Command sequencing.
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state <= H_IDLE;
      wait_cnt <= 10'h000;
      ref_since_exit <= 1'b1;
      bus.cs_n <= 1'b1;
      bus.ras_n <= 1'b1;
      bus.cas_n <= 1'b1;
      bus.we_n <= 1'b1;
      bus.cke <= 1'b1;
      bus.termination_control_pin <= 1'b0;
      bus.addr <= '0;
      in_self_refresh_o <= 1'b0;
      dll_ready_o <= 1'b1;
    end else if (clk_en_i) begin
      {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'hF;
      case (state)
        H_IDLE: begin
          bus.termination_control_pin <= 1'b1; // R21
          if (issue_ref) begin // R02 R07 R10
            {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h1;
            ref_since_exit <= 1'b1; // R22
            wait_cnt <= 10'(`RFC_CYC);
            state <= H_REF_WAIT;
          end else if (sr_req_i && ref_since_exit) begin // R11 R14
            bus.termination_control_pin <= 1'b0; // R15
            wait_cnt <= 10'(`ODT_LEAD_CYC);
            state <= H_ODT_OFF;
          end
        end
        H_REF_WAIT: begin
          if (wait_cnt == 10'h000) state <= H_IDLE; // R05
          else wait_cnt <= wait_cnt - 1'b1;
        end
        H_ODT_OFF: begin
          if (wait_cnt == 10'h000) begin
            {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h1;
            bus.cke <= 1'b0; // R16
            in_self_refresh_o <= 1'b1;
            dll_ready_o <= 1'b0;
            wait_cnt <= 10'(`CKESR_CYC);
            state <= H_SELF;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        H_SELF: begin
          if (wait_cnt != 10'h000) wait_cnt <= wait_cnt - 1'b1; // R19
          else if (sr_exit_i) begin
            bus.cke <= 1'b1; // R20
            in_self_refresh_o <= 1'b0;
            ref_since_exit <= 1'b0;
            wait_cnt <= 10'(`XS_CYC);
            state <= H_XS;
          end
        end
        H_XS: begin
          if (wait_cnt == 10'h000) begin // R21
            wait_cnt <= 10'(`XSDLL_CYC - `XS_CYC);
            state <= H_XSDLL;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        H_XSDLL: begin
          if (wait_cnt == 10'h000) begin
            dll_ready_o <= 1'b1; // R20
            state <= H_IDLE;
          end else begin
            wait_cnt <= wait_cnt - 1'b1;
          end
        end
        default: begin
          state <= H_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Write gate after self-refresh exit.
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      wr_cnt <= 10'h000;
      write_ok_o <= 1'b1;
    end else if (clk_en_i) begin
      if (state == H_SELF && sr_exit_i && wait_cnt == 10'h000) begin
        wr_cnt <= 10'(`WRLVL_CYC - 1);
        write_ok_o <= 1'b0; // R23
      end else if (wr_cnt != 10'h000) begin
        wr_cnt <= wr_cnt - 1'b1;
      end else if (state != H_SELF) begin
        write_ok_o <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

//--- testbench/refresh_props.sv
`timescale 1ns/100ps
`default_nettype none
module refresh_props (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Bus and status
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic cke,
  input wire logic termination_control_pin,
  input wire logic refresh_busy_o,
  input wire logic refresh_pulse_o,
  input wire logic self_refresh_o
);
  // ----
  // Checks
  // ----
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  wire logic rc = !cs_n && !ras_n && !cas_n && we_n;
  wire logic nop = cs_n || (ras_n && cas_n && we_n);
  sequence nops_s;
    nop [*6];
  endsequence
  sequence held_s;
    (cke && !termination_control_pin) [*8];
  endsequence
  ref_take_a: assert property (rc && cke && $past(cke) && !refresh_busy_o
    && !self_refresh_o |=> refresh_pulse_o) else $error("refresh not taken");
  busy_len_a: assert property ($rose(refresh_busy_o) |-> refresh_busy_o [*6]
    ##1 !refresh_busy_o) else $error("busy length wrong");
  ref_gap_a: assert property (rc && cke |=> nops_s) else $error("command in gap");
  sre_take_a: assert property (rc && !cke && $past(cke) && !self_refresh_o
    && !refresh_busy_o |=> self_refresh_o) else $error("entry not taken");
  sr_hold_a: assert property (self_refresh_o && !cke |=> self_refresh_o)
    else $error("self refresh lost");
  term_off_a: assert property (rc && !cke && $past(cke) |-> !termination_control_pin
    && !$past(termination_control_pin, 5)) else $error("termination on");
  int_ref_a: assert property ($rose(self_refresh_o) |-> ##[1:3] refresh_pulse_o)
    else $error("no internal refresh");
  exit_nop_a: assert property (cke && !$past(cke) |-> nops_s and held_s)
    else $error("exit sequence wrong");
endmodule
`default_nettype wire

//--- testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "refresh_map.svh"
module testbench;
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic sr_req_i = 1'b0;
  logic sr_exit_i = 1'b0;
  logic dll_enable_i = 1'b0;
  logic busy, sr, dll_on, dll_rst, pulse, banks, in_sr, dll_rdy, wr_ok;
  logic [`ROW_W-1:0] row;
  logic signed [`DEBT_W-1:0] debt;
  logic signed [`DEBT_W-1:0] d0;
  integer rst_cnt = 0;
  integer r0 = 0;
  integer pulse_cnt = 0;
  integer err_count = 0;
  integer check_count = 0;
  integer seed = 32'h57fd9bc9;
  integer n, t;
  integer cyc = 0;
  int q[$];
  refresh_if bus ();
  refresh_device i_refresh_device (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .clk_en_i(1'b1),
    .bus(bus), .dll_enable_i(dll_enable_i), .refresh_busy_o(busy), .self_refresh_o(sr),
    .dll_on_o(dll_on), .dll_reset_o(dll_rst), .refresh_pulse_o(pulse),
    .refresh_row_o(row), .banks_idle_o(banks));
  refresh_host i_refresh_host (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .clk_en_i(1'b1),
    .sr_req_i(sr_req_i), .sr_exit_i(sr_exit_i), .bus(bus), .in_self_refresh_o(in_sr),
    .dll_ready_o(dll_rdy), .write_ok_o(wr_ok), .debt_o(debt));
  refresh_props i_refresh_props (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cs_n(bus.cs_n),
    .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n), .cke(bus.cke),
    .termination_control_pin(bus.termination_control_pin), .refresh_busy_o(busy),
    .refresh_pulse_o(pulse), .self_refresh_o(sr));
  // ----
  // Helpers
  // ----
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [31:0] exp_row(input integer pulses);
    return pulses % (1 << `ROW_W);
  endfunction
  task wait_sr(input logic v);
    n = 0;
    while (in_sr !== v && n < 1000) begin
      @(posedge ref_clk_i);
      #2;
      n++;
    end
    chk("sr_wait", 1, n < 1000);
  endtask
  always #25 ref_clk_i = ~ref_clk_i;
  always @(negedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (dll_rst === 1'b1) begin
      rst_cnt <= rst_cnt + 1;
    end
    if (pulse === 1'b1) begin
      pulse_cnt <= pulse_cnt + 1;
    end
    if (rstn_i) begin
      chk("debt_range", 1, debt <= `DEBT_MAX && debt >= -`DEBT_MAX);
      if (bus.cke && !bus.cs_n && !bus.ras_n && !bus.cas_n && bus.we_n) begin
        while (q.size() > 0 && cyc - q[0] >= 2 * `REFI_CYC) q.pop_front();
        q.push_back(cyc);
        chk("refs_per_window", 1, q.size() <= 16);
      end
    end
  end
  // ----
  // Tests
  // ----
  initial begin
    #(50 * 20000);
    err_count++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge ref_clk_i);
    #2 rstn_i = 1'b1;
    chk("debt", 0, debt);
    chk("banks_idle", 1, banks);
    chk("write_ok", 1, wr_ok);
    @(posedge ref_clk_i);
    #2;
    chk("debt_early", 32'hFFFFFFFF, debt);
    for (t = 0; t < 3; t++) begin
      n = $random(seed);
      dll_enable_i = n[0];
      repeat (200 + n[9:2]) @(posedge ref_clk_i);
      #2 sr_req_i = 1'b1;
      wait_sr(1'b1);
      d0 = debt;
      repeat (`CKESR_CYC + 20) @(posedge ref_clk_i);
      #2;
      chk("dll_on_sr", 0, dll_on);
      chk("self_refresh", 1, sr);
      chk("debt_frozen", d0, debt);
      r0 = rst_cnt;
      sr_req_i = 1'b0;
      sr_exit_i = 1'b1;
      wait_sr(1'b0);
      sr_exit_i = 1'b0;
      chk("write_ok_exit", 0, wr_ok);
      chk("dll_ready_exit", 0, dll_rdy);
      n = 0;
      while (dll_rdy !== 1'b1 && n < 2000) begin
        @(posedge ref_clk_i);
        #2;
        n++;
      end
      chk("exit_delay", 1, n >= `XSDLL_CYC && n < 2000);
      chk("dll_reset", dll_enable_i, rst_cnt - r0);
      chk("dll_on_exit", dll_enable_i, dll_on);
      chk("write_ok_late", 1, wr_ok);
      chk("refresh_row", exp_row(pulse_cnt), row);
      $display("test %0d done", t);
    end
    end_sim;
  end
endmodule
`default_nettype wire
